// ==== vc_arbitration_cap_regs.sv ====
// Purpose: Port VC capability 2, port VC control and status, and the low
//   half of VC resource 0 capability, reached over an AHB-Lite slave.
// Assumes: Single word transfers; upstream_port_i is a static strap.
// Notes: Only VC0 exists, so the arbitration select is stored but idle.
//
// Overview of operation
// - VC arbitration capability field reads all zeros.
// - Capability bit 0 fixed RR; bits 1-3 WRR 32/64/128; 4-7 reserved.
// - VC arbitration capability counts only when low-priority VC count > 0.
// - VC arbitration table offset at 31:24 reads zero: no table.
// - Load VC arbitration table bit is read-only zero with no action.
// - Writable 3-bit arbitration select at 3:1, reset zero, no effect.
// - VC arbitration table status bit reads zero.
// - Port arbitration capability reads 0x3 upstream, 0x1 downstream.
// - Port capability bits: fixed RR, WRR 32/64/128, timed WRR, WRR 256.
// - Advanced packet switching and reject snoop bits read zero.
// - Low-priority extended VC count is zero.
`timescale 1ns/100ps
`include "vc_arb_defines.svh"

module vc_arbitration_cap_regs
	import vc_arb_pkg::*;
#(
	parameter int ADDR_W = `VCR_ADDR_W
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic upstream_port_i,
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [2:0] vc_arbitration_select_o,
	output logic upstream_port_o
);

	// Refuse an address bus too narrow to reach the highest register.
	generate
		if (ADDR_W < `VCR_ADDR_W_MIN)
		begin : g_addr_check
			$error("ADDR_W too small for the register map.");
		end
	endgenerate

	// Maps an address to its one-hot register select.
	function automatic reg_sel_type decode_sel(input logic [ADDR_W-1:0] a);
		reg_sel_type s;
		s = SEL_NONE;
		if (a == ADDR_W'(`PORT_VC_CAP_TWO_IDX * `VCR_BYTES_PER_IDX))
			s = SEL_CAP_TWO;
		else if (a == ADDR_W'(`PORT_VC_CONTROL_IDX * `VCR_BYTES_PER_IDX))
			s = SEL_CONTROL;
		else if (a == ADDR_W'(`PORT_VC_STATUS_IDX * `VCR_BYTES_PER_IDX))
			s = SEL_STATUS;
		else if (a == ADDR_W'(`VC_RES_ZERO_CAP_IDX * `VCR_BYTES_PER_IDX))
			s = SEL_RES_CAP;
		return s;
	endfunction : decode_sel

	// Builds the read word for a select from the live state.
	function automatic logic [31:0] read_word(input reg_sel_type s,
		input logic [2:0] arb_sel, input logic up);
		logic [31:0] w;
		logic [7:0] parb;
		w = 32'h0000_0000;
		parb = 8'h00;
		parb[`PARB_FIXED_RR_BIT] = 1'b1;
		parb[`PARB_WRR32_BIT] = up;
		unique case (s)
			SEL_CAP_TWO:
			begin
				// Field left zero; reserved bits never set.
				// Gated by the fixed zero count.
				if (`LP_EXT_VC_COUNT != 3'h0)
					w[`VC_ARB_CAP_MSB:`VC_ARB_CAP_LSB] = `VC_ARB_CAP_VALUE;
				w[`VC_ARB_TBL_OFF_MSB:`VC_ARB_TBL_OFF_LSB] =
					`VC_ARB_TABLE_OFFSET;
			end
			SEL_CONTROL:
			begin
				w[`LOAD_VC_ARB_TBL_BIT] = 1'b0;
				w[`VC_ARB_SEL_MSB:`VC_ARB_SEL_LSB] = arb_sel;
			end
			SEL_STATUS:
			begin
				w[`VC_ARB_TBL_STS_BIT] = 1'b0;
			end
			SEL_RES_CAP:
			begin
				w[`PORT_ARB_CAP_MSB:`PORT_ARB_CAP_LSB] = parb;
				w[`ADV_PKT_SWITCH_BIT] = 1'b0;
				w[`REJECT_SNOOP_BIT] = 1'b0;
			end
			SEL_NONE:
			begin
				w = 32'h0000_0000;
			end
			default:
			begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction : read_word

	logic rd_acc;
	logic wr_acc;
	reg_sel_type addr_sel;
	reg_sel_type wr_sel_reg;
	reg_sel_type wr_sel_next;
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic hreadyout_reg;
	logic hreadyout_next;
	logic hresp_reg;
	logic hresp_next;
	logic [2:0] arb_sel_reg;
	logic [2:0] arb_sel_next;
	logic upstream_reg;
	logic upstream_next;

	// Address phase qualifiers for accepted transfers; only writes must be word-sized.
	assign addr_sel = decode_sel(haddr_i);
	assign rd_acc = hsel_i && hready_i && !hwrite_i &&
		(htrans_i == `AHB_TRANS_NONSEQ);
	assign wr_acc = hsel_i && hready_i && hwrite_i &&
		(htrans_i == `AHB_TRANS_NONSEQ) && (hsize_i == `AHB_SIZE_WORD);

	// Control state: arbitration select and the port strap.
	always_comb
	begin
		arb_sel_next = arb_sel_reg;
		upstream_next = upstream_reg;
		if (wr_pend_reg && (wr_sel_reg == SEL_CONTROL))
			arb_sel_next = hwdata_i[`VC_ARB_SEL_MSB:`VC_ARB_SEL_LSB];
		if (sys_rst_i)
		begin
			arb_sel_next = `VC_ARB_SEL_RESET;
			upstream_next = upstream_port_i;
		end
	end

	// Registers the control state.
	always_ff @(posedge clk_i)
	begin
		arb_sel_reg <= arb_sel_next;
		upstream_reg <= upstream_next;
	end

	// Bus state: pending write, read data and ready.
	always_comb
	begin
		wr_pend_next = wr_acc;
		wr_sel_next = wr_acc ? addr_sel : SEL_NONE;
		hrdata_next = hrdata_reg;
		hreadyout_next = 1'b1;
		hresp_next = `AHB_RESP_OKAY;
		// Reserved and read-only bits come from read_word only.
		if (rd_acc)
			hrdata_next = read_word(addr_sel, arb_sel_next, upstream_reg);
		if (sys_rst_i)
		begin
			wr_pend_next = 1'b0;
			wr_sel_next = SEL_NONE;
			hrdata_next = 32'h0000_0000;
		end
	end

	// Registers the bus state; zero wait states, always OKAY.
	always_ff @(posedge clk_i)
	begin
		wr_pend_reg <= wr_pend_next;
		wr_sel_reg <= wr_sel_next;
		hrdata_reg <= hrdata_next;
		hreadyout_reg <= hreadyout_next;
		hresp_reg <= hresp_next;
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = hreadyout_reg;
	assign hresp_o = hresp_reg;
	assign vc_arbitration_select_o = arb_sel_reg;
	assign upstream_port_o = upstream_reg;

	a_vc_cap_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CAP_TWO) |=>
		hrdata_o[`VC_ARB_CAP_MSB:`VC_ARB_CAP_LSB] == 8'h00)
		else $error("VC arbitration capability not zero.");

	a_cap_rsvd_bits: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CAP_TWO) |=>
		hrdata_o[`VC_ARB_CAP_MSB:`VC_ARB_CAP_RSVD_LSB] == 4'h0)
		else $error("Reserved VC capability bits set.");

	a_cap_count_gate: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CAP_TWO) |=>
		(hrdata_o[`VC_ARB_CAP_MSB:`VC_ARB_CAP_LSB] == 8'h00) ||
		(`LP_EXT_VC_COUNT != 3'h0))
		else $error("Capability reported with zero VC count.");

	a_tbl_off_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CAP_TWO) |=>
		hrdata_o[`VC_ARB_TBL_OFF_MSB:`VC_ARB_TBL_OFF_LSB] == 8'h00)
		else $error("VC arbitration table offset not zero.");

	a_load_bit_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CONTROL) |=>
		!hrdata_o[`LOAD_VC_ARB_TBL_BIT])
		else $error("Load VC table bit read as one.");

	// Written select is stored and driven on vc_arbitration_select_o.
	a_sel_written: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		wr_pend_reg && (wr_sel_reg == SEL_CONTROL) |=>
		vc_arbitration_select_o ==
		$past(hwdata_i[`VC_ARB_SEL_MSB:`VC_ARB_SEL_LSB]))
		else $error("Arbitration select not stored.");

	a_sel_reset: assert property (@(posedge clk_i)
		sys_rst_i |=> vc_arbitration_select_o == `VC_ARB_SEL_RESET)
		else $error("Arbitration select not reset.");

	a_status_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_STATUS) |=>
		hrdata_o == 32'h0000_0000)
		else $error("Port VC status not zero.");

	a_port_cap_val: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_RES_CAP) |=>
		hrdata_o[`PORT_ARB_CAP_MSB:`PORT_ARB_CAP_LSB] ==
		(upstream_port_o ? `PORT_ARB_CAP_UP : `PORT_ARB_CAP_DOWN))
		else $error("Port arbitration capability wrong.");

	// Only fixed round robin and 32-phase WRR may be advertised.
	a_parb_encoding: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_RES_CAP) |=>
		hrdata_o[`PARB_FIXED_RR_BIT] &&
		(hrdata_o[`PORT_ARB_CAP_MSB:`PARB_WRR64_BIT] == 6'h00))
		else $error("Port arbitration encoding has a wrong bit.");

	a_feature_bits: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_RES_CAP) |=>
		hrdata_o[`REJECT_SNOOP_BIT:`ADV_PKT_SWITCH_BIT] == 2'h0)
		else $error("Switching or snoop bit set.");

	// Writes elsewhere leave the select alone.
	a_ro_write_ignored: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		wr_pend_reg && (wr_sel_reg != SEL_CONTROL) |=>
		$stable(vc_arbitration_select_o))
		else $error("Read-only write changed state.");

	a_ctl_rsvd_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CONTROL) |=>
		hrdata_o[`VCR_WORD_MSB:`VC_ARB_SEL_MSB+1] == 28'h0)
		else $error("Control reserved bits set.");

	// Capability two reserved bits read zero.
	a_cap2_rsvd_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_CAP_TWO) |=>
		hrdata_o[`VC_ARB_TBL_OFF_LSB-1:`VC_ARB_CAP_MSB+1] == 16'h0000)
		else $error("Capability two reserved bits set.");

	// Resource capability reserved bits read zero.
	a_res_rsvd_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_RES_CAP) |=>
		(hrdata_o[`ADV_PKT_SWITCH_BIT-1:`PORT_ARB_CAP_MSB+1] == 6'h00) &&
		(hrdata_o[`VCR_WORD_MSB:`HALF_MSB+1] == 16'h0000))
		else $error("Resource capability reserved bits set.");

	a_unmapped_zero: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		rd_acc && (addr_sel == SEL_NONE) |=>
		hrdata_o == 32'h0000_0000)
		else $error("Unmapped address read not zero.");

	// Ignored writes still finish with no wait and OKAY.
	a_resp_okay: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		wr_pend_reg |-> hreadyout_o && (hresp_o == `AHB_RESP_OKAY))
		else $error("Write data phase not ready and OKAY.");

endmodule : vc_arbitration_cap_regs

// ==== vc_arb_defines.svh ====
// Purpose: Constants for the port VC arbitration capability register bank.
// Assumes: AHB-Lite access with one 32-bit word per register.
// Notes: Register indices are kept as printed; byte address is index * 4.
`ifndef VC_ARB_DEFINES_SVH
`define VC_ARB_DEFINES_SVH

// Address width and the smallest width that reaches every register.
`define VCR_ADDR_W 12
`define VCR_ADDR_W_MIN 12
`define VCR_BYTES_PER_IDX 4

// Register indices.
`define PORT_VC_CAP_TWO_IDX 12'h208
`define PORT_VC_CONTROL_IDX 12'h20C
`define PORT_VC_STATUS_IDX 12'h20E
`define VC_RES_ZERO_CAP_IDX 12'h210

// AHB-Lite encodings.
`define AHB_TRANS_NONSEQ 2'h2
`define AHB_SIZE_WORD 3'h2
`define AHB_RESP_OKAY 1'h0

// Fixed capability values and the select reset value.
`define VC_ARB_CAP_VALUE 8'h00
`define VC_ARB_TABLE_OFFSET 8'h00
`define LP_EXT_VC_COUNT 3'h0
`define VC_ARB_SEL_RESET 3'h0
`define PORT_ARB_CAP_UP 8'h03
`define PORT_ARB_CAP_DOWN 8'h01

// Field positions.
`define VC_ARB_CAP_LSB 0
`define VC_ARB_CAP_RSVD_LSB 4
`define VC_ARB_CAP_MSB 7
`define VC_ARB_TBL_OFF_LSB 24
`define VC_ARB_TBL_OFF_MSB 31
`define LOAD_VC_ARB_TBL_BIT 0
`define VC_ARB_SEL_LSB 1
`define VC_ARB_SEL_MSB 3
`define VC_ARB_TBL_STS_BIT 0
`define PORT_ARB_CAP_LSB 0
`define PORT_ARB_CAP_MSB 7
`define ADV_PKT_SWITCH_BIT 14
`define REJECT_SNOOP_BIT 15
`define HALF_MSB 15
`define VCR_WORD_MSB 31

// Port arbitration capability encoding bits.
`define PARB_FIXED_RR_BIT 0
`define PARB_WRR32_BIT 1
`define PARB_WRR64_BIT 2
`define PARB_WRR128_BIT 3
`define PARB_TWRR128_BIT 4
`define PARB_WRR256_BIT 5

`endif

// ==== vc_arb_pkg.sv ====
// Purpose: Types for the port VC arbitration capability register bank.
// Assumes: Used together with vc_arb_defines.svh.
// Notes: Register selects are one-hot codes.
package vc_arb_pkg;

	// One-hot register select decoded from the bus address.
	typedef enum logic [4:0]
	{
		SEL_NONE = 5'h01,
		SEL_CAP_TWO = 5'h02,
		SEL_CONTROL = 5'h04,
		SEL_STATUS = 5'h08,
		SEL_RES_CAP = 5'h10
	} reg_sel_type;

endpackage : vc_arb_pkg

// ==== test_vc_arbitration_cap_regs.sv ====
// Purpose: Self-checking bench for the VC arbitration capability registers.
// Assumes: AHB-Lite slave, single word transfers except one halfword write, hready tied to hreadyout.
// Notes: Byte address is the register index times four.
`timescale 1ns/100ps
`include "vc_arb_defines.svh"

module test_vc_arbitration_cap_regs
	import vc_arb_pkg::*;
;
	localparam logic [11:0] cap2_addr =
		12'(`PORT_VC_CAP_TWO_IDX * `VCR_BYTES_PER_IDX);
	localparam logic [11:0] ctl_addr =
		12'(`PORT_VC_CONTROL_IDX * `VCR_BYTES_PER_IDX);
	localparam logic [11:0] sts_addr =
		12'(`PORT_VC_STATUS_IDX * `VCR_BYTES_PER_IDX);
	localparam logic [11:0] res_addr =
		12'(`VC_RES_ZERO_CAP_IDX * `VCR_BYTES_PER_IDX);
	localparam int cycle_limit = 3000;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic up = 1'b0;
	logic hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [2:0] sel_out;
	logic up_out;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	// The clock toggles every 12.5 ns, for a period of 25 ns.
	always #12.5 clk = ~clk;

	vc_arbitration_cap_regs #(.ADDR_W(12)) DUT
	(
		.clk_i(clk),
		.sys_rst_i(rst),
		.upstream_port_i(up),
		.hsel_i(hsel),
		.haddr_i(haddr),
		.htrans_i(htrans),
		.hwrite_i(hwrite),
		.hsize_i(hsize),
		.hwdata_i(hwdata),
		.hready_i(hreadyout),
		.hrdata_o(hrdata),
		.hreadyout_o(hreadyout),
		.hresp_o(hresp),
		.vc_arbitration_select_o(sel_out),
		.upstream_port_o(up_out)
	);

	// Prints the verdict and ends the run.
	task automatic give_verdict;
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// Compares a seen value with the expected one and counts mismatches.
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One AHB-Lite single transfer: address phase, then data phase.
	task automatic bus(input logic [11:0] addr, input logic wr,
		input logic [2:0] size, input logic [31:0] wdata,
		output logic [31:0] rdata);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr;
		hsize <= size;
		htrans <= `AHB_TRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wdata;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdata = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask : bus

	// Reads one word and compares it.
	task automatic rd(input string name, input logic [11:0] addr,
		input logic [31:0] exp);
		logic [31:0] d;
		bus(addr, 1'b0, `AHB_SIZE_WORD, 32'h0, d);
		check(name, d, exp);
	endtask : rd

	// Writes one word of the given size.
	task automatic wr(input logic [11:0] addr, input logic [31:0] data,
		input logic [2:0] size);
		logic [31:0] d;
		bus(addr, 1'b1, size, data, d);
	endtask : wr

	// Reads every read-only word, writes ones to it, and reads it again.
	task automatic ro_sweep(input logic [31:0] res_exp);
		logic [11:0] a;
		logic [31:0] e;
		for (int i = 0; i < 5; i++)
		begin
			e = 32'h0;
			case (i)
				0: a = cap2_addr;
				1: a = sts_addr;
				2: a = res_addr;
				3: a = 12'h844;
				default: a = 12'h000;
			endcase
			if (i == 2)
				e = res_exp;
			rd("ro word", a, e);
			wr(a, 32'hFFFFFFFF, `AHB_SIZE_WORD);
			rd("ro after write", a, e);
		end
	endtask : ro_sweep

	// Cuts a hang short and closes the run as failed.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == cycle_limit)
		begin
			failures++;
			give_verdict();
		end
	end

	// Main sequence of tests.
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd("control reset", ctl_addr, 32'h0);
		check("strap", {31'h0, up_out}, 32'h0);
		ro_sweep(32'h1);
		// Select storage with the load bit set.
		for (int i = 0; i < 8; i++)
		begin
			wr(ctl_addr, {28'hFFFFFFF, 3'(i), 1'b1}, `AHB_SIZE_WORD);
			rd("control", ctl_addr, {28'h0, 3'(i), 1'b0});
			check("select out", {29'h0, sel_out}, 32'(i));
		end
		wr(ctl_addr, 32'h0, 3'h1);
		rd("control half", ctl_addr, 32'h0000000E);
		// Upstream strap after a new reset.
		@(posedge clk);
		rst <= 1'b1;
		up <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd("control reset", ctl_addr, 32'h0);
		check("select reset", {29'h0, sel_out}, 32'h0);
		check("strap", {31'h0, up_out}, 32'h1);
		ro_sweep(32'h3);
		give_verdict();
	end
endmodule : test_vc_arbitration_cap_regs
